// File: hdl/bbr_regs.v
// Summary of operation
// - Two copies of registers 0x61 to 0x73: low band and high band.
// - Bit 3 of the operating mode register picks the copy reached.
// - Toggling band select leaves both copies' contents unchanged.
// - Band select resets to 1, selecting the low-band copy.
// - 0x61 holds six-bit floor level; bits 7-6 read zero; resets 0x19/0x1c.
// - Reference equals -174 + bandwidth term + 8 dB + floor level.
// - 0x62 holds five-bit first threshold; bits 7-5 read zero; 0x0c/0x0e.
// - 0x63: second threshold high nibble 0x4/0x5, third low nibble 0xb.
// - 0x64: fourth and fifth thresholds, both nibbles reset to 0xc.
// - 0x70 bits 7-6 pick loop bandwidth 75 to 300 kHz; reset 3.
// - 0x70 bits 5-0 are writable reserved, reset 0x10; keep that value.
// - Band select 0 reaches high-band copy, 1 reaches low-band copy.
`include "bbr_consts.vh"
`default_nettype none

module bbr_regs #(
   parameter ADDR_W = 12
) (
   // Clock and reset
   input  wire              clk,
   input  wire              reset,
   // AXI4-Lite write address
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire [2:0]        s_axi_awprot,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   // AXI4-Lite read address
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire [2:0]        s_axi_arprot,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   // Receiver bandwidth term 10*log10(2*bw), in dB, from the modem
   input  wire [7:0]        receiver_bandwidth_db,
   // Active band settings towards the radio
   output reg               band_select_low_q,
   output reg  [5:0]        gain_floor_level_q,
   output reg  [4:0]        gain_threshold_first_q,
   output reg  [3:0]        gain_threshold_second_q,
   output reg  [3:0]        gain_threshold_third_q,
   output reg  [3:0]        gain_threshold_fourth_q,
   output reg  [3:0]        gain_threshold_fifth_q,
   output reg  [1:0]        synth_loop_bandwidth_q,
   output reg  [5:0]        synth_loop_reserved_q,
   output reg  [9:0]        agc_reference_dbm_q
);

   // Write channel state
   reg  [ADDR_W-1:0] aw_addr_q;
   reg               aw_full_q;
   reg  [7:0]        w_data_q;
   reg               w_lane0_q;
   reg               w_full_q;
   // Read channel state
   reg  [ADDR_W-1:0] ar_addr_q;
   reg               ar_full_q;
   // Operating mode register, band select only
   reg               band_sel_q;

   // Bank contents, copy 0 high band, copy 1 low band
   wire [11:0]       floor_w;
   wire [9:0]        thr1_w;
   wire [15:0]       thr23_w;
   wire [15:0]       thr45_w;
   wire [15:0]       synth_w;

   // Decoded write
   wire [6:0]        wr_idx;
   wire              wr_top_zero;
   wire              wr_banked;
   wire              wr_known;
   wire              wr_go;
   wire              wr_opmode;
   // Decoded read
   wire [6:0]        rd_idx;
   wire              rd_top_zero;
   reg  [7:0]        rd_byte;
   reg               rd_known;
   // Fields of the copy that band select points at
   wire [5:0]        sel_floor;
   wire [4:0]        sel_thr1;
   wire [7:0]        sel_thr23;
   wire [7:0]        sel_thr45;
   wire [7:0]        sel_synth;
   // Reference level terms, widened to the sum's width
   wire [9:0]        ref_bw_term;
   wire [9:0]        ref_floor_term;
   // Store strobe, only when byte lane 0 was enabled
   wire              wr_store;

   // Low-band reset words shown on the outputs during reset
   localparam [7:0] LF_THR23 = `BBR_LF_THR23_RST;
   localparam [7:0] LF_THR45 = `BBR_LF_THR45_RST;
   localparam [7:0] LF_SYNTH = `BBR_LF_SYNTH_RST;

   // Write address decode
   assign wr_idx      = aw_addr_q[8:2];
   assign wr_top_zero = (aw_addr_q[ADDR_W-1:9] == {(ADDR_W-9){1'b0}});
   assign wr_banked   = wr_top_zero &&
                        (wr_idx >= `BBR_IDX_BANK_LO) &&
                        (wr_idx <= `BBR_IDX_BANK_HI);
   assign wr_known    = wr_top_zero &&
                        ((wr_idx == `BBR_IDX_OPMODE) ||
                         (wr_idx == `BBR_IDX_FLOOR) ||
                         (wr_idx == `BBR_IDX_THR1) ||
                         (wr_idx == `BBR_IDX_THR23) ||
                         (wr_idx == `BBR_IDX_THR45) ||
                         (wr_idx == `BBR_IDX_SYNTH));
   // One store per response; bvalid blocks a repeat of the same write
   assign wr_go       = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wr_store    = wr_go && w_lane0_q;
   assign wr_opmode   = wr_store && wr_top_zero &&
                        (wr_idx == `BBR_IDX_OPMODE);

   // Read address decode
   assign rd_idx      = ar_addr_q[8:2];
   assign rd_top_zero = (ar_addr_q[ADDR_W-1:9] == {(ADDR_W-9){1'b0}});

   // Selected copy; copy 1 is the low band
   assign sel_floor   = band_sel_q ? floor_w[11:6] : floor_w[5:0];
   assign sel_thr1    = band_sel_q ? thr1_w[9:5] : thr1_w[4:0];
   assign sel_thr23   = band_sel_q ? thr23_w[15:8] : thr23_w[7:0];
   assign sel_thr45   = band_sel_q ? thr45_w[15:8] : thr45_w[7:0];
   assign sel_synth   = band_sel_q ? synth_w[15:8] : synth_w[7:0];

   // Reference terms; the sum wraps as two's complement dBm
   assign ref_bw_term    = {2'b00, receiver_bandwidth_db};
   assign ref_floor_term = {4'h0, sel_floor};

   // Two band copies, each written only while selected
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_band
         bbr_bank #(
            .FLOOR_RST (g ? `BBR_LF_FLOOR_RST : `BBR_HF_FLOOR_RST),
            .THR1_RST  (g ? `BBR_LF_THR1_RST  : `BBR_HF_THR1_RST),
            .THR23_RST (g ? `BBR_LF_THR23_RST : `BBR_HF_THR23_RST),
            .THR45_RST (g ? `BBR_LF_THR45_RST : `BBR_HF_THR45_RST),
            .SYNTH_RST (g ? `BBR_LF_SYNTH_RST : `BBR_HF_SYNTH_RST)
         ) u_bank (
            .clk     (clk),
            .reset   (reset),
            .wr_en   (wr_store && wr_banked &&
                      (band_sel_q == g)),
            .wr_idx  (wr_idx),
            .wr_data (w_data_q),
            .floor_q (floor_w[g*6 +: 6]),
            .thr1_q  (thr1_w[g*5 +: 5]),
            .thr23_q (thr23_w[g*8 +: 8]),
            .thr45_q (thr45_w[g*8 +: 8]),
            .synth_q (synth_w[g*8 +: 8])
         );
      end
   endgenerate

   // Read mux over the selected copy; unused bits read zero
   always @* begin
      rd_byte  = 8'h00;
      rd_known = 1'b0;
      if (rd_top_zero) begin
         case (rd_idx)
            `BBR_IDX_OPMODE: begin
               rd_byte[`BBR_BAND_SEL_BIT] = band_sel_q;
               rd_known = 1'b1;
            end
            `BBR_IDX_FLOOR: begin
               rd_byte  = {2'b00, sel_floor};
               rd_known = 1'b1;
            end
            `BBR_IDX_THR1: begin
               rd_byte  = {3'b000, sel_thr1};
               rd_known = 1'b1;
            end
            `BBR_IDX_THR23: begin
               rd_byte  = sel_thr23;
               rd_known = 1'b1;
            end
            `BBR_IDX_THR45: begin
               rd_byte  = sel_thr45;
               rd_known = 1'b1;
            end
            `BBR_IDX_SYNTH: begin
               rd_byte  = sel_synth;
               rd_known = 1'b1;
            end
            default: begin
               rd_byte  = 8'h00;
               rd_known = 1'b0;
            end
         endcase
      end
   end

   // Band select bit; other copy is left as it is
   // Only a write with lane 0 enabled can move it
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         band_sel_q <= `BBR_BAND_SEL_RST;
      end else if (wr_opmode) begin
         band_sel_q <= w_data_q[`BBR_BAND_SEL_BIT];
      end
   end

   // Write address channel
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         aw_full_q     <= 1'b0;
         aw_addr_q     <= {ADDR_W{1'b0}};
      end else begin
         if (s_axi_awready && s_axi_awvalid) begin
            aw_full_q     <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            aw_full_q     <= 1'b0;
         end else if (!aw_full_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
      end
   end

   // Write data channel, only byte lane 0 carries data
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_wready <= 1'b0;
         w_full_q     <= 1'b0;
         w_data_q     <= 8'h00;
         w_lane0_q    <= 1'b0;
      end else begin
         if (s_axi_wready && s_axi_wvalid) begin
            w_full_q     <= 1'b1;
            w_data_q     <= s_axi_wdata[7:0];
            w_lane0_q    <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            w_full_q     <= 1'b0;
         end else if (!w_full_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Write response once both halves are held
   // Unmapped offsets are answered but stored nowhere
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `BBR_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_known ? `BBR_RESP_OKAY : `BBR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read address channel
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         ar_full_q     <= 1'b0;
         ar_addr_q     <= {ADDR_W{1'b0}};
      end else begin
         if (s_axi_arready && s_axi_arvalid) begin
            ar_full_q     <= 1'b1;
            ar_addr_q     <= s_axi_araddr;
            s_axi_arready <= 1'b0;
         end else if (ar_full_q && !s_axi_rvalid) begin
            ar_full_q     <= 1'b0;
         end else if (!ar_full_q && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Read data channel
   // Data comes from the copy selected at the capturing edge
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `BBR_RESP_OKAY;
      end else if (ar_full_q && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, rd_byte};
         s_axi_rresp  <= rd_known ? `BBR_RESP_OKAY : `BBR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Active band fields towards the radio
   // Outputs lag the selected copy by one clock
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         band_select_low_q       <= `BBR_BAND_SEL_RST;
         gain_floor_level_q      <= `BBR_LF_FLOOR_RST;
         gain_threshold_first_q  <= `BBR_LF_THR1_RST;
         gain_threshold_second_q <= LF_THR23[7:4];
         gain_threshold_third_q  <= LF_THR23[3:0];
         gain_threshold_fourth_q <= LF_THR45[7:4];
         gain_threshold_fifth_q  <= LF_THR45[3:0];
         synth_loop_bandwidth_q  <= LF_SYNTH[7:6];
         synth_loop_reserved_q   <= LF_SYNTH[5:0];
      end else begin
         band_select_low_q       <= band_sel_q;
         gain_floor_level_q      <= sel_floor;
         gain_threshold_first_q  <= sel_thr1;
         gain_threshold_second_q <= sel_thr23[7:4];
         gain_threshold_third_q  <= sel_thr23[3:0];
         gain_threshold_fourth_q <= sel_thr45[7:4];
         gain_threshold_fifth_q  <= sel_thr45[3:0];
         synth_loop_bandwidth_q  <= sel_synth[7:6];
         synth_loop_reserved_q   <= sel_synth[5:0];
      end
   end

   // Reference level, two's complement dBm
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         agc_reference_dbm_q <= 10'h000;
      end else begin
         agc_reference_dbm_q <= `BBR_NOISE_FLOOR_DBM + ref_bw_term +
                                `BBR_SNR_DB + ref_floor_term;
      end
   end

endmodule // bbr_regs

`default_nettype wire

// File: shared/bbr_consts.vh
`ifndef BBR_CONSTS_VH
`define BBR_CONSTS_VH

// Register indices; byte address is four times the index
`define BBR_IDX_OPMODE      7'h01
`define BBR_IDX_FLOOR       7'h61
`define BBR_IDX_THR1        7'h62
`define BBR_IDX_THR23       7'h63
`define BBR_IDX_THR45       7'h64
`define BBR_IDX_SYNTH       7'h70
`define BBR_IDX_BANK_LO     7'h61
`define BBR_IDX_BANK_HI     7'h73

// Operating mode register fields
`define BBR_BAND_SEL_BIT    3
`define BBR_BAND_SEL_RST    1'b1
`define BBR_BAND_HIGH       1'b0
`define BBR_BAND_LOW        1'b1

// Field widths
`define BBR_FLOOR_W         6
`define BBR_THR1_W          5

// Low-band reset values
`define BBR_LF_FLOOR_RST    6'h19
`define BBR_LF_THR1_RST     5'h0c
`define BBR_LF_THR23_RST    8'h4b
`define BBR_LF_THR45_RST    8'hcc
`define BBR_LF_SYNTH_RST    8'hd0

// High-band reset values
`define BBR_HF_FLOOR_RST    6'h1c
`define BBR_HF_THR1_RST     5'h0e
`define BBR_HF_THR23_RST    8'h5b
`define BBR_HF_THR45_RST    8'hcc
`define BBR_HF_SYNTH_RST    8'hd0

// Reference level arithmetic, in dBm and dB
`define BBR_NOISE_FLOOR_DBM 10'h352
`define BBR_SNR_DB          10'h008

// AXI4-Lite responses
`define BBR_RESP_OKAY       2'b00
`define BBR_RESP_SLVERR     2'b10

`endif

// File: hdl/bbr_bank.v
`include "bbr_consts.vh"
`default_nettype none

module bbr_bank #(
   parameter [5:0] FLOOR_RST = 6'h00,
   parameter [4:0] THR1_RST  = 5'h00,
   parameter [7:0] THR23_RST = 8'h00,
   parameter [7:0] THR45_RST = 8'h00,
   parameter [7:0] SYNTH_RST = 8'h00
) (
   // Clock and reset
   input  wire       clk,
   input  wire       reset,
   // Write port from the bus slave
   input  wire       wr_en,
   input  wire [6:0] wr_idx,
   input  wire [7:0] wr_data,
   // Stored contents
   output reg  [5:0] floor_q,
   output reg  [4:0] thr1_q,
   output reg  [7:0] thr23_q,
   output reg  [7:0] thr45_q,
   output reg  [7:0] synth_q
);

   // One band copy; only touched when this copy is addressed
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         floor_q <= FLOOR_RST;
         thr1_q  <= THR1_RST;
         thr23_q <= THR23_RST;
         thr45_q <= THR45_RST;
         synth_q <= SYNTH_RST;
      end else if (wr_en) begin
         case (wr_idx)
            `BBR_IDX_FLOOR: floor_q <= wr_data[5:0];
            `BBR_IDX_THR1:  thr1_q  <= wr_data[4:0];
            `BBR_IDX_THR23: thr23_q <= wr_data;
            `BBR_IDX_THR45: thr45_q <= wr_data;
            `BBR_IDX_SYNTH: synth_q <= wr_data;
            default: begin
            end
         endcase
      end
   end

endmodule // bbr_bank

`default_nettype wire

// File: verification/bbr_regs_props.sv
`include "bbr_consts.vh"
`default_nettype none
module bbr_regs_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // Bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Radio side
   input wire logic [7:0]  receiver_bandwidth_db,
   input wire logic        band_select_low_q,
   input wire logic [5:0]  gain_floor_level_q,
   input wire logic [9:0]  agc_reference_dbm_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // Inputs of the reference sum held steady
   sequence s_calm;
      $stable(receiver_bandwidth_db) && $stable(gain_floor_level_q);
   endsequence
   // Answers hold until taken
   chk_bresp_held: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_rdata_held: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   // Answer timing
   chk_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid) else $error("write answer late");
   chk_read_answer: assert property (
      $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready, 2))
      else $error("read answer without request");
   // No new request while one is pending
   chk_write_busy: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   chk_read_busy: assert property (
      s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   // Byte wide registers, upper bits zero
   chk_rdata_pad: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   chk_band_reset: assert property (
      $fell(reset) |-> band_select_low_q) else $error("band select not low");
   chk_ref_sum: assert property (
      s_calm [*3] |-> agc_reference_dbm_q == `BBR_NOISE_FLOOR_DBM
      + {2'h0, receiver_bandwidth_db} + `BBR_SNR_DB
      + {4'h0, gain_floor_level_q}) else $error("reference sum wrong");
   // Main scenarios reached
   cov_write: cover property (s_axi_bvalid && s_axi_bready);
   cov_read: cover property (s_axi_rvalid && s_axi_rready);
   cov_high: cover property ($fell(band_select_low_q));
endmodule // bbr_regs_props
bind bbr_regs bbr_regs_props i_props (
   .clk(clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .receiver_bandwidth_db(receiver_bandwidth_db),
   .band_select_low_q(band_select_low_q),
   .gain_floor_level_q(gain_floor_level_q),
   .agc_reference_dbm_q(agc_reference_dbm_q));
`default_nettype wire

// File: verification/bbr_regs_tb.sv
`include "bbr_consts.vh"
`default_nettype none
module bbr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Bus and radio signals
   logic        clk, reset, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, bsl;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdat, rd;
   logic [1:0]  brs, rrs, rsp, lbw;
   logic [7:0]  receiver_bandwidth;
   logic [5:0]  flr, rsv;
   logic [4:0]  t1;
   logic [3:0]  t2, t3, t4, t5;
   logic [9:0]  refd;
   int          miscompares, checks_done;
   // Banked indices, reset contents per band, written values
   logic [6:0] ix [5] = '{7'h61, 7'h62, 7'h63, 7'h64, 7'h70};
   logic [7:0] lo [5] = '{8'h19, 8'h0c, 8'h4b, 8'hcc, 8'hd0};
   logic [7:0] hi [5] = '{8'h1c, 8'h0e, 8'h5b, 8'hcc, 8'hd0};
   logic [7:0] wv4 [4] = '{8'hff, 8'hff, 8'ha5, 8'h3c};
   logic [7:0] nw [5] = '{8'h3f, 8'h1f, 8'ha5, 8'h3c, 8'h10};

   bbr_regs #(.ADDR_W(12)) i_dut (
      .clk(clk), .reset(reset), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrs),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .receiver_bandwidth_db(receiver_bandwidth),
      .band_select_low_q(bsl), .gain_floor_level_q(flr),
      .gain_threshold_first_q(t1), .gain_threshold_second_q(t2),
      .gain_threshold_third_q(t3), .gain_threshold_fourth_q(t4),
      .gain_threshold_fifth_q(t5), .synth_loop_bandwidth_q(lbw),
      .synth_loop_reserved_q(rsv), .agc_reference_dbm_q(refd));

   // Free running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e, s);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   // One bus access, write or read; readies sampled mid cycle
   task automatic acc(input logic w, input logic [6:0] i,
                      input logic [7:0] d, input logic [1:0] er);
      int n;
      logic a, g, b;
      n = 0;
      @(posedge clk);
      if (w) begin
         awa <= {3'h0, i, 2'b00};
         wd <= {24'h0, d};
         awv <= 1'b1;
         wv <= 1'b1;
         br <= 1'b1;
      end else begin
         ara <= {3'h0, i, 2'b00};
         arv <= 1'b1;
         rr <= 1'b1;
      end
      do begin
         @(negedge clk);
         a = w ? awr : arr;
         g = wr;
         b = w ? bv : rv;
         rsp = w ? brs : rrs;
         rd = rdat;
         @(posedge clk);
         if (a) begin
            awv <= 1'b0;
            arv <= 1'b0;
         end
         if (g) wv <= 1'b0;
         if (b) begin
            br <= 1'b0;
            rr <= 1'b0;
         end
         n++;
      end while (!b && n < 40);
      chk("bus answer", 1'b1, b);
      chk("response", er, rsp);
   endtask

   // Read and compare the data byte
   task automatic rdc(input logic [6:0] i, input logic [7:0] e);
      acc(1'b0, i, 8'h00, `BBR_RESP_OKAY);
      chk("read data", {24'h0, e}, rd);
   endtask

   // Verdict and end of run
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      final_report();
   end

   // Test sequence
   initial begin
      {reset, awv, wv, br, arv, rr} = 6'h20;
      {awa, ara, wd, receiver_bandwidth} = '0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      chk("band after reset", 1'b1, bsl);
      rdc(`BBR_IDX_OPMODE, 8'h08);
      for (int i = 0; i < 5; i++) rdc(ix[i], lo[i]);
      @(negedge clk);
      chk("floor out", 6'h19, flr);
      chk("loop out", 2'b11, lbw);
      chk("reserved out", 6'h10, rsv);
      acc(1'b1, `BBR_IDX_OPMODE, 8'h00, `BBR_RESP_OKAY);
      for (int i = 0; i < 5; i++) rdc(ix[i], hi[i]);
      for (int i = 0; i < 4; i++) acc(1'b1, ix[i], wv4[i], 2'b00);
      for (int k = 3; k >= 0; k--) begin
         acc(1'b1, 7'h70, {k[1:0], 6'h10}, `BBR_RESP_OKAY);
         rdc(7'h70, {k[1:0], 6'h10});
         @(negedge clk);
         chk("loop out", k[1:0], lbw);
      end
      @(posedge clk);
      receiver_bandwidth <= 8'd80;
      repeat (3) @(negedge clk);
      // -174 + 80 + 8 + 63 = -23 dBm as ten-bit two's complement
      chk("reference", 10'h3e9, refd);
      chk("band out", 1'b0, bsl);
      chk("floor out", 6'h3f, flr);
      chk("first out", 5'h1f, t1);
      chk("second out", 4'ha, t2);
      chk("third out", 4'h5, t3);
      chk("fourth out", 4'h3, t4);
      chk("fifth out", 4'hc, t5);
      chk("reserved out", 6'h10, rsv);
      acc(1'b1, `BBR_IDX_OPMODE, 8'h08, `BBR_RESP_OKAY);
      for (int i = 0; i < 5; i++) rdc(ix[i], lo[i]);
      @(negedge clk);
      chk("band out", 1'b1, bsl);
      chk("first out", 5'h0c, t1);
      chk("second out", 4'h4, t2);
      chk("third out", 4'hb, t3);
      acc(1'b1, `BBR_IDX_OPMODE, 8'h00, `BBR_RESP_OKAY);
      for (int i = 0; i < 5; i++) rdc(ix[i], nw[i]);
      rdc(`BBR_IDX_OPMODE, 8'h00);
      acc(1'b0, 7'h65, 8'h00, `BBR_RESP_SLVERR);
      chk("unmapped data", 32'h0, rd);
      acc(1'b1, 7'h72, 8'h55, `BBR_RESP_SLVERR);
      final_report();
   end
endmodule // bbr_regs_tb
`default_nettype wire
